// ---- design/lpw_map.vh ----
// Register map, reset values and timing constants of the power controller
`ifndef LPW_MAP_VH
`define LPW_MAP_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define LPW_OFS_WAKE_LEVEL   8'h00
`define LPW_OFS_WAKE_ENABLE  8'h04
`define LPW_OFS_XTAL_SEL     8'h08
`define LPW_OFS_LP_DIR       8'h0C
`define LPW_OFS_LP_OUT       8'h10
`define LPW_OFS_LP_DRIVE     8'h14
`define LPW_OFS_LP_PULL      8'h18
`define LPW_OFS_POWER_CMD    8'h1C
`define LPW_OFS_STATUS       8'h20

// ----------------------------------------------------------------------
// Field widths and positions
// ----------------------------------------------------------------------
`define LPW_NUM_WAKE         5
`define LPW_NUM_LP_PINS      3
`define LPW_CMD_STANDBY      0
`define LPW_CMD_SLEEP        1
`define LPW_ST_LSB           0
`define LPW_ST_W             6
`define LPW_CAUSE_PIN_LSB    8
`define LPW_CAUSE_TMR_BIT    13
`define LPW_XTAL_BIT         0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LPW_RST_WAKE_LEVEL   5'h00
`define LPW_RST_WAKE_ENABLE  5'h07
`define LPW_RST_XTAL_SEL     1'b0
`define LPW_RST_LP_DIR       3'h7
`define LPW_RST_LP_OUT       3'h0
`define LPW_RST_LP_DRIVE     3'h0
`define LPW_RST_LP_PULL      3'h7
`define LPW_ZERO_WORD        32'h0000_0000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define LPW_CLK_PERIOD_NS    10
`define LPW_WAKE_TIME_NS     200000
`define LPW_PRE_CYCLES       16

`endif

// ---- design/lpw_wake_det.v ----
// Wake request qualifier for the five wake pins and the radio timers
`timescale 1ns/100ps
`default_nettype none

module lpw_wake_det #(
    parameter NPIN = 5
) (
    input  wire            clk,
    input  wire            sys_rst,
    input  wire [NPIN-1:0] pin_in,
    input  wire [NPIN-1:0] level_sel,
    input  wire [NPIN-1:0] pin_en,
    input  wire            in_standby,
    input  wire            in_sleep,
    input  wire            radio_timer_expired,
    output reg  [NPIN-1:0] pin_hit_ff,
    output reg             timer_hit_ff
);

    // ------------------------------------------------------------------
    // Qualification
    // ------------------------------------------------------------------
    // Matching level per pin: 1 wakes on high, 0 wakes on low
    wire [NPIN-1:0] level_match = ~(pin_in ^ level_sel);
    wire            low_power   = in_standby | in_sleep;

    // Pins count in both low-power states, timers only in sleep
    always @(posedge clk) begin
        if (sys_rst) begin
            pin_hit_ff   <= {NPIN{1'b0}};
            timer_hit_ff <= 1'b0;
        end else begin
            pin_hit_ff   <= low_power ? (level_match & pin_en)
                                      : {NPIN{1'b0}};
            timer_hit_ff <= in_sleep & radio_timer_expired;
        end
    end

endmodule

`default_nettype wire

// ---- design/lpw_pin_hold.v ----
// Low-power pad settings for the three configurable wake pins
`timescale 1ns/100ps
`default_nettype none

`include "lpw_map.vh"

module lpw_pin_hold #(
    parameter NPIN = 3
) (
    input  wire            clk,
    input  wire            sys_rst,
    input  wire            low_power,
    input  wire [NPIN-1:0] dir,
    input  wire [NPIN-1:0] out_val,
    input  wire [NPIN-1:0] drive,
    input  wire [NPIN-1:0] pull,
    input  wire [NPIN-1:0] wake_en,
    output reg  [NPIN-1:0] pad_out_ff,
    output reg  [NPIN-1:0] pad_oe_n_ff,
    output reg  [NPIN-1:0] pad_drive_ff,
    output reg  [NPIN-1:0] pad_pull_ff
);

    // ------------------------------------------------------------------
    // Pad control
    // ------------------------------------------------------------------
    // Outside low power the pads belong to the normal GPIO logic, so
    // this block releases them; pulls stay on as the pad default.
    always @(posedge clk) begin
        if (sys_rst) begin
            pad_out_ff   <= `LPW_RST_LP_OUT;
            pad_oe_n_ff  <= `LPW_RST_LP_DIR;
            pad_drive_ff <= `LPW_RST_LP_DRIVE;
            pad_pull_ff  <= `LPW_RST_LP_PULL;
        end else if (low_power) begin
            pad_out_ff   <= out_val;
            pad_oe_n_ff  <= dir | wake_en;
            pad_drive_ff <= drive;
            pad_pull_ff  <= pull;
        end else begin
            pad_out_ff   <= out_val;
            pad_oe_n_ff  <= {NPIN{1'b1}};
            pad_drive_ff <= drive;
            pad_pull_ff  <= {NPIN{1'b1}};
        end
    end

endmodule

`default_nettype wire

// ---- design/lpw_ctrl.v ----
// Power state sequencer, clock source control and register bank
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none

`include "lpw_map.vh"

// Behaviour
// - After reset the sequencer always goes to preactive first.
// - Preactive runs the system clock from the internal 16 MHz RC.
// - Preactive runs the low-frequency clock from the 32.768 kHz RC.
// - Active switches to the 16 MHz crystal and stops the fast RC.
// - Standby keeps only retention supply; regulators, BOR, oscillators off.
// - Standby wakes only on an enabled pin at its programmed level.
// - Sleep keeps retention supply and the low-frequency oscillator running.
// - Sleep wakes on an enabled pin level or a radio timer expiry.
// - Both RAM banks stay in retention in every state.
// - Wake level register at 0x00: 0 low wakes, 1 high wakes.
// - Wake enable register at 0x04: 1 lets the pin wake the device.
// - Register 0x0C sets low-power pin direction, 0 output, reset 0x7.
// - Register 0x10 sets the level driven by low-power output pins.
// - Register 0x14 selects low-power drive strength per pin.
// - Register 0x18 enables low-power pulls, independent of direction.
// - Wake-enabled configurable pins ignore direction but keep pull setting.
// - First three wake pins pull up by default; last two have none.
// - Return from low power to running takes about 200 us.
// - Wake bits 4:0 map to pins in order; enable resets to 0x07.
// - Control bit 0 selects crystal: 0 is 16 MHz, 1 is 32 MHz.
module lpw_ctrl #(
    parameter AW          = 8,
    parameter CW          = 16,
    parameter WAKE_CYCLES = `LPW_WAKE_TIME_NS / `LPW_CLK_PERIOD_NS,
    parameter PRE_CYCLES  = `LPW_PRE_CYCLES
) (
    input  wire                        clk,
    input  wire                        sys_rst,
    input  wire [AW-1:0]               reg_addr,
    input  wire [31:0]                 reg_wdata,
    input  wire                        reg_wr,
    input  wire                        reg_rd,
    output reg  [31:0]                 reg_rdata_ff,
    input  wire [`LPW_NUM_WAKE-1:0]    wake_pin_in,
    input  wire                        radio_timer_expired,
    output reg                         main_reg_on_ff,
    output reg                         bor_on_ff,
    output reg                         ret_supply_on_ff,
    output reg  [1:0]                  ram_bank_ret_ff,
    output reg                         hf_rc_on_ff,
    output reg                         hf_xo_on_ff,
    output reg                         hf_sel_xo_ff,
    output reg                         lf_osc_on_ff,
    output reg                         xtal_32m_ff,
    output reg  [`LPW_ST_W-1:0]        power_state_ff,
    output wire [`LPW_NUM_LP_PINS-1:0] lp_pin_out_ff,
    output wire [`LPW_NUM_LP_PINS-1:0] lp_pin_oe_n_ff,
    output wire [`LPW_NUM_LP_PINS-1:0] lp_pin_drive_ff,
    output wire [`LPW_NUM_LP_PINS-1:0] lp_pin_pull_ff
);

    // ------------------------------------------------------------------
    // States, one-hot
    // ------------------------------------------------------------------
    localparam [5:0] ST_RESET   = 6'h01;
    localparam [5:0] ST_PREACT  = 6'h02;
    localparam [5:0] ST_ACTIVE  = 6'h04;
    localparam [5:0] ST_STANDBY = 6'h08;
    localparam [5:0] ST_SLEEP   = 6'h10;
    localparam [5:0] ST_WAKING  = 6'h20;

    localparam NW = `LPW_NUM_WAKE;
    localparam NP = `LPW_NUM_LP_PINS;

    // Integer sums cut to the counter width on purpose
    localparam integer  WAKE_LAST_I = WAKE_CYCLES - 1;
    localparam integer  PRE_LAST_I  = PRE_CYCLES - 1;
    localparam [CW-1:0] WAKE_LAST   = WAKE_LAST_I[CW-1:0];
    localparam [CW-1:0] PRE_LAST    = PRE_LAST_I[CW-1:0];

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Address compare, shared by the write and read decoders
    function hit;
        input [AW-1:0] addr;
        input [7:0]    ofs;
        begin
            hit = (addr == ofs[AW-1:0]);
        end
    endfunction

    // Place a narrow field at the bottom of a zeroed word
    function [31:0] low_field;
        input [7:0] val;
        begin
            low_field = {24'h00_0000, val};
        end
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    reg  [NW-1:0] wake_level_ff;
    reg  [NW-1:0] wake_enable_ff;
    reg  [NP-1:0] lp_dir_ff;
    reg  [NP-1:0] lp_out_ff;
    reg  [NP-1:0] lp_drive_ff;
    reg  [NP-1:0] lp_pull_ff;
    reg  [1:0]    lp_req_ff;
    reg  [NW-1:0] cause_pin_ff;
    reg           cause_tmr_ff;
    reg  [5:0]    state_ff;
    reg  [5:0]    nxt_state;
    reg  [CW-1:0] cnt_ff;
    reg  [CW-1:0] nxt_cnt;
    reg  [31:0]   nxt_rdata;

    wire [NW-1:0] pin_hit;
    wire          timer_hit;
    wire          any_wake = (|pin_hit) | timer_hit;
    wire          in_low   = state_ff[3] | state_ff[4] | state_ff[5];

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    // Only the documented low bits are stored; the rest read zero.
    always @(posedge clk) begin
        if (sys_rst) begin
            wake_level_ff  <= `LPW_RST_WAKE_LEVEL;
            wake_enable_ff <= `LPW_RST_WAKE_ENABLE;
            xtal_32m_ff    <= `LPW_RST_XTAL_SEL;
            lp_dir_ff      <= `LPW_RST_LP_DIR;
            lp_out_ff      <= `LPW_RST_LP_OUT;
            lp_drive_ff    <= `LPW_RST_LP_DRIVE;
            lp_pull_ff     <= `LPW_RST_LP_PULL;
        end else if (reg_wr) begin
            if (hit(reg_addr, `LPW_OFS_WAKE_LEVEL))
                wake_level_ff <= reg_wdata[NW-1:0];
            if (hit(reg_addr, `LPW_OFS_WAKE_ENABLE))
                wake_enable_ff <= reg_wdata[NW-1:0];
            if (hit(reg_addr, `LPW_OFS_XTAL_SEL))
                xtal_32m_ff <= reg_wdata[`LPW_XTAL_BIT];
            if (hit(reg_addr, `LPW_OFS_LP_DIR))
                lp_dir_ff <= reg_wdata[NP-1:0];
            if (hit(reg_addr, `LPW_OFS_LP_OUT))
                lp_out_ff <= reg_wdata[NP-1:0];
            if (hit(reg_addr, `LPW_OFS_LP_DRIVE))
                lp_drive_ff <= reg_wdata[NP-1:0];
            if (hit(reg_addr, `LPW_OFS_LP_PULL))
                lp_pull_ff <= reg_wdata[NP-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Low-power command
    // ------------------------------------------------------------------
    // A request is held until the sequencer is active and can act on it,
    // so a command written during preactive is not lost.
    always @(posedge clk) begin
        if (sys_rst) begin
            lp_req_ff <= 2'b00;
        end else if (reg_wr && hit(reg_addr, `LPW_OFS_POWER_CMD)) begin
            lp_req_ff <= reg_wdata[1:0];
        end else if (state_ff == ST_ACTIVE) begin
            lp_req_ff <= 2'b00;
        end
    end

    // ------------------------------------------------------------------
    // Wake qualification
    // ------------------------------------------------------------------
    lpw_wake_det #(
        .NPIN (NW)
    ) u_wake (
        .clk                 (clk),
        .sys_rst             (sys_rst),
        .pin_in              (wake_pin_in),
        .level_sel           (wake_level_ff),
        .pin_en              (wake_enable_ff),
        .in_standby          (state_ff == ST_STANDBY),
        .in_sleep            (state_ff == ST_SLEEP),
        .radio_timer_expired (radio_timer_expired),
        .pin_hit_ff          (pin_hit),
        .timer_hit_ff        (timer_hit)
    );

    // ------------------------------------------------------------------
    // Low-power pad settings
    // ------------------------------------------------------------------
    lpw_pin_hold #(
        .NPIN (NP)
    ) u_pins (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .low_power    (in_low),
        .dir          (lp_dir_ff),
        .out_val      (lp_out_ff),
        .drive        (lp_drive_ff),
        .pull         (lp_pull_ff),
        .wake_en      (wake_enable_ff[NP-1:0]),
        .pad_out_ff   (lp_pin_out_ff),
        .pad_oe_n_ff  (lp_pin_oe_n_ff),
        .pad_drive_ff (lp_pin_drive_ff),
        .pad_pull_ff  (lp_pin_pull_ff)
    );

    // ------------------------------------------------------------------
    // State sequencer
    // ------------------------------------------------------------------
    // The hit flags are one cycle old; the state change is taken in the cycle
    // they are set, as they clear once the pin stops matching or the state moves on.
    always @* begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        case (state_ff)
            ST_RESET: begin
                nxt_state = ST_PREACT;
                nxt_cnt   = {CW{1'b0}};
            end
            ST_PREACT: begin
                // Short settling window before the crystal takes over
                if (cnt_ff == PRE_LAST) begin
                    nxt_state = ST_ACTIVE;
                    nxt_cnt   = {CW{1'b0}};
                end else begin
                    nxt_cnt = cnt_ff + 1'b1;
                end
            end
            ST_ACTIVE: begin
                if (lp_req_ff[`LPW_CMD_STANDBY])
                    nxt_state = ST_STANDBY;
                else if (lp_req_ff[`LPW_CMD_SLEEP])
                    nxt_state = ST_SLEEP;
            end
            ST_STANDBY: begin
                if (|pin_hit) begin
                    nxt_state = ST_WAKING;
                    nxt_cnt   = {CW{1'b0}};
                end
            end
            ST_SLEEP: begin
                if (any_wake) begin
                    nxt_state = ST_WAKING;
                    nxt_cnt   = {CW{1'b0}};
                end
            end
            ST_WAKING: begin
                // Supplies and RC ramp for the wake-up time, then
                // the normal preactive path brings the crystal in.
                if (cnt_ff == WAKE_LAST) begin
                    nxt_state = ST_PREACT;
                    nxt_cnt   = {CW{1'b0}};
                end else begin
                    nxt_cnt = cnt_ff + 1'b1;
                end
            end
            default: begin
                nxt_state = ST_RESET;
                nxt_cnt   = {CW{1'b0}};
            end
        endcase
    end

    // State and counter flops
    always @(posedge clk) begin
        if (sys_rst) begin
            state_ff <= ST_RESET;
            cnt_ff   <= {CW{1'b0}};
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    // ------------------------------------------------------------------
    // Wake cause capture
    // ------------------------------------------------------------------
    // Latched on the wake edge and kept until the next wake, so
    // software can read why it woke; no clear path is needed.
    always @(posedge clk) begin
        if (sys_rst) begin
            cause_pin_ff <= {NW{1'b0}};
            cause_tmr_ff <= 1'b0;
        end else if (in_low && nxt_state == ST_WAKING &&
                     state_ff != ST_WAKING) begin
            cause_pin_ff <= pin_hit;
            cause_tmr_ff <= timer_hit;
        end
    end

    // ------------------------------------------------------------------
    // Supply and clock controls
    // ------------------------------------------------------------------
    // Supply groups of the next state; one-hot, so a compare is enough
    wire nxt_run = (nxt_state == ST_PREACT) | (nxt_state == ST_ACTIVE) |
                   (nxt_state == ST_WAKING);
    wire nxt_rc  = (nxt_state == ST_PREACT) | (nxt_state == ST_WAKING);
    wire nxt_act = (nxt_state == ST_ACTIVE);
    wire nxt_lf  = nxt_run | (nxt_state == ST_SLEEP);
    // Decoded from the next state so the outputs line up with
    // power_state_ff in the same cycle.
    always @(posedge clk) begin
        if (sys_rst) begin
            main_reg_on_ff   <= 1'b0;
            bor_on_ff        <= 1'b0;
            ret_supply_on_ff <= 1'b0;
            ram_bank_ret_ff  <= 2'b11;
            hf_rc_on_ff      <= 1'b0;
            hf_xo_on_ff      <= 1'b0;
            hf_sel_xo_ff     <= 1'b0;
            lf_osc_on_ff     <= 1'b0;
            power_state_ff   <= ST_RESET;
        end else begin
            power_state_ff   <= nxt_state;
            ram_bank_ret_ff  <= 2'b11;
            ret_supply_on_ff <= (nxt_state != ST_RESET);
            main_reg_on_ff   <= nxt_run;
            bor_on_ff        <= nxt_run;
            hf_rc_on_ff      <= nxt_rc;
            hf_xo_on_ff      <= nxt_act;
            hf_sel_xo_ff     <= nxt_act;
            lf_osc_on_ff     <= nxt_lf;
        end
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------
    // Unmapped offsets and the write-only command word read as zero.
    always @* begin
        nxt_rdata = `LPW_ZERO_WORD;
        if (hit(reg_addr, `LPW_OFS_WAKE_LEVEL))
            nxt_rdata = low_field({3'b000, wake_level_ff});
        else if (hit(reg_addr, `LPW_OFS_WAKE_ENABLE))
            nxt_rdata = low_field({3'b000, wake_enable_ff});
        else if (hit(reg_addr, `LPW_OFS_XTAL_SEL))
            nxt_rdata = low_field({7'h00, xtal_32m_ff});
        else if (hit(reg_addr, `LPW_OFS_LP_DIR))
            nxt_rdata = low_field({5'h00, lp_dir_ff});
        else if (hit(reg_addr, `LPW_OFS_LP_OUT))
            nxt_rdata = low_field({5'h00, lp_out_ff});
        else if (hit(reg_addr, `LPW_OFS_LP_DRIVE))
            nxt_rdata = low_field({5'h00, lp_drive_ff});
        else if (hit(reg_addr, `LPW_OFS_LP_PULL))
            nxt_rdata = low_field({5'h00, lp_pull_ff});
        else if (hit(reg_addr, `LPW_OFS_STATUS)) begin
            nxt_rdata[`LPW_ST_LSB +: `LPW_ST_W] = state_ff;
            nxt_rdata[`LPW_CAUSE_PIN_LSB +: NW] = cause_pin_ff;
            nxt_rdata[`LPW_CAUSE_TMR_BIT]       = cause_tmr_ff;
        end
    end

    // Read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        if (sys_rst)
            reg_rdata_ff <= `LPW_ZERO_WORD;
        else if (reg_rd)
            reg_rdata_ff <= nxt_rdata;
        else
            reg_rdata_ff <= `LPW_ZERO_WORD;
    end

endmodule

`default_nettype wire

// ---- tb/lpw_ctrl_asserts.sv ----
// Port assertions for the power state controller
`timescale 1ns/100ps
`default_nettype none
module lpw_ctrl_chk (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata_ff,
    input wire logic        main_reg_on_ff,
    input wire logic        bor_on_ff,
    input wire logic        ret_supply_on_ff,
    input wire logic [1:0]  ram_bank_ret_ff,
    input wire logic        hf_rc_on_ff,
    input wire logic        hf_xo_on_ff,
    input wire logic        hf_sel_xo_ff,
    input wire logic        lf_osc_on_ff,
    input wire logic [5:0]  power_state_ff
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ----------------------------------------------------------------
    // Supplies and clocks must follow the one-hot state; reset and wake must lead to preactive
    // ----------------------------------------------------------------
    a_ram_ret_kept: assert property (ram_bank_ret_ff == 2'b11)
        else $error("ram retention dropped");
    a_boot_pre: assert property ($fell(sys_rst) |=>
        power_state_ff == 6'h02) else $error("reset did not go preactive");
    a_pre_rc_clk: assert property (power_state_ff == 6'h02 |->
        hf_rc_on_ff && !hf_sel_xo_ff && lf_osc_on_ff && main_reg_on_ff)
        else $error("preactive clocks wrong");
    a_active_xo: assert property (power_state_ff == 6'h04 |->
        hf_xo_on_ff && hf_sel_xo_ff && !hf_rc_on_ff)
        else $error("active clocks wrong");
    a_standby_off: assert property (power_state_ff == 6'h08 |->
        ret_supply_on_ff && !main_reg_on_ff && !bor_on_ff && !lf_osc_on_ff
        && !hf_rc_on_ff && !hf_xo_on_ff) else $error("standby supplies on");
    a_sleep_lf_on: assert property (power_state_ff == 6'h10 |->
        ret_supply_on_ff && lf_osc_on_ff && !main_reg_on_ff && !bor_on_ff)
        else $error("sleep supplies wrong");
    a_wake_to_pre: assert property ($fell(power_state_ff[5]) |->
        power_state_ff == 6'h02) else $error("wake skipped preactive");
    // Read data only stands the cycle after a read strobe
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata_ff == 32'h0000_0000)
        else $error("read data not cleared");
endmodule
bind lpw_ctrl lpw_ctrl_chk lpw_ctrl_chk_i (.clk(clk), .sys_rst(sys_rst),
    .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .main_reg_on_ff(main_reg_on_ff), .bor_on_ff(bor_on_ff),
    .ret_supply_on_ff(ret_supply_on_ff), .ram_bank_ret_ff(ram_bank_ret_ff),
    .hf_rc_on_ff(hf_rc_on_ff), .hf_xo_on_ff(hf_xo_on_ff),
    .hf_sel_xo_ff(hf_sel_xo_ff), .lf_osc_on_ff(lf_osc_on_ff),
    .power_state_ff(power_state_ff));
`default_nettype wire

// ---- tb/lpw_ctrl_bench.sv ----
// Self-checking bench for the power state controller
`timescale 1ns/100ps
`default_nettype none
module low_power_state_wakeup_control_bench;
    logic clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0, tmr = 0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata_ff, d;
    logic [4:0] pins = 5'h1F;
    logic m, b, r, rc, xo, sx, lf, x32;
    logic [1:0] rb;
    logic [5:0] st;
    logic [2:0] po, poe, pdr, ppu;
    int n_fail = 0, check_count = 0, cyc = 0;
    lpw_ctrl #(.WAKE_CYCLES(20), .PRE_CYCLES(4)) lpw_ctrl_i (.clk(clk),
        .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
        .wake_pin_in(pins), .radio_timer_expired(tmr), .main_reg_on_ff(m),
        .bor_on_ff(b), .ret_supply_on_ff(r), .ram_bank_ret_ff(rb),
        .hf_rc_on_ff(rc), .hf_xo_on_ff(xo), .hf_sel_xo_ff(sx),
        .lf_osc_on_ff(lf), .xtal_32m_ff(x32), .power_state_ff(st),
        .lp_pin_out_ff(po), .lp_pin_oe_n_ff(poe), .lp_pin_drive_ff(pdr),
        .lp_pin_pull_ff(ppu));
    initial forever #5 clk = ~clk;
    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            give_verdict;
        end
    end
    task give_verdict;
        if (n_fail == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task chk(input string s, input logic [31:0] seen, input logic [31:0] e);
        check_count++;
        if (seen !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", s, e, seen);
        end
    endtask
    // ----------------------------------------------------------------
    // Register bus master and state waiting
    // ----------------------------------------------------------------
    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk); reg_wr <= 1; reg_addr <= a; reg_wdata <= v;
        @(posedge clk); reg_wr <= 0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk); reg_rd <= 1; reg_addr <= a;
        @(posedge clk); reg_rd <= 0;
        #1 d = reg_rdata_ff;
    endtask
    task wait_st(input logic [5:0] s, input int lim);
        int n;
        n = 0;
        while (st !== s && n < lim) begin
            @(posedge clk); #1 n++;
        end
        chk("state", {26'h0, st}, {26'h0, s});
    endtask
    task t_regs;
        logic [7:0] a;
        logic [31:0] rv [8] = '{0, 7, 0, 7, 0, 0, 7, 0};
        logic [31:0] mk [8] = '{31, 31, 1, 7, 7, 7, 7, 0};
        for (int i = 0; i < 8; i++) begin
            a = (i == 7) ? 8'h24 : 8'(i * 4);
            rd(a);
            chk("reset value", d, rv[i]);
            wr(a, 32'hFFFF_FFFF);
            rd(a);
            chk("masked rw", d, mk[i]);
        end
        chk("xtal flag", {31'h0, x32}, 32'h0000_0001);
    endtask
    // Standby: pads held, only enabled pin at its level wakes
    task t_standby;
        wr(8'h00, 0); wr(8'h04, 1); wr(8'h0C, 5); wr(8'h10, 2);
        wr(8'h14, 2); wr(8'h18, 3); wr(8'h1C, 1);
        wait_st(6'h08, 10); repeat (2) @(posedge clk); #1;
        chk("oe_n", {29'h0, poe}, 32'h0000_0005);
        chk("out", {31'h0, po[1]}, 32'h0000_0001);
        chk("drive", {29'h0, pdr}, 32'h0000_0002);
        chk("pull", {29'h0, ppu}, 32'h0000_0003);
        @(posedge clk); tmr <= 1; pins <= 5'h0F;
        repeat (4) @(posedge clk); tmr <= 0; pins <= 5'h1F; #1;
        chk("no wake", {26'h0, st}, 32'h0000_0008);
        @(posedge clk); pins <= 5'h1E;
        wait_st(6'h20, 3);
        @(posedge clk); pins <= 5'h1F;
        wait_st(6'h02, 22);
        wait_st(6'h04, 6);
        rd(8'h20);
        chk("cause", {26'h0, d[13:8]}, 32'h0000_0001);
        chk("released", {26'h0, poe, ppu}, 32'h0000_003F);
    endtask
    // Sleep: radio timer expiry wakes, then a high-level pin wakes
    task t_sleep;
        wr(8'h1C, 2);
        wait_st(6'h10, 10);
        @(posedge clk); tmr <= 1;
        @(posedge clk); tmr <= 0;
        wait_st(6'h20, 3);
        wait_st(6'h04, 40);
        rd(8'h20);
        chk("timer cause", {31'h0, d[13]}, 32'h0000_0001);
        // High-level wake pin idles low, biased against its wake level
        @(posedge clk); pins <= 5'h17;
        wr(8'h00, 8);
        wr(8'h04, 8);
        wr(8'h1C, 2);
        wait_st(6'h10, 10);
        @(posedge clk); pins <= 5'h1F;
        wait_st(6'h20, 3);
        wait_st(6'h04, 40);
        rd(8'h20);
        chk("pin cause", {26'h0, d[13:8]}, 32'h0000_0008);
    endtask
    initial begin
        repeat (5) @(posedge clk);
        sys_rst <= 0;
        @(posedge clk); #1 chk("boot", {26'h0, st}, 32'h0000_0002);
        wait_st(6'h04, 8);
        t_regs; t_standby; t_sleep;
        give_verdict;
    end
endmodule
`default_nettype wire
